// ### core/apd_defs.svh
`ifndef APD_DEFS_SVH
`define APD_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets on the apb port
`define APD_OFF_STRENGTH 8'h00
`define APD_OFF_CTRL_A 8'h04
`define APD_OFF_CTRL_B 8'h08
`define APD_OFF_SAMPLE_LO 8'h0c
`define APD_OFF_SAMPLE_HI 8'h10

////////////////////////////////////////////////////////////////////////////////
// reset values
`define APD_STRENGTH_RST 8'h04
`define APD_CTRL_A_RST 8'h00
`define APD_CTRL_B_RST 8'h00
`define APD_SAMPLE_RST 8'h00

// implemented bits; the rest read as zero
`define APD_STRENGTH_MASK 8'h0f
`define APD_CTRL_A_MASK 8'hef
`define APD_CTRL_B_MASK 8'h8f

////////////////////////////////////////////////////////////////////////////////
// control a field positions
`define APD_CA_MODE 7
`define APD_CA_RES_HI 6
`define APD_CA_RES_LO 5
`define APD_CA_MUTE_N 3
`define APD_CA_PLL 2
`define APD_CA_DRV 1
`define APD_CA_EN 0

////////////////////////////////////////////////////////////////////////////////
// pwm timing and widths
`define APD_FIRST_SAMPLE 16'h8000
`define APD_TICK_DIV 1
`define APD_RES_BASE 5'd9
`define APD_SAMPLE_W 5'd16

`endif

// ### core/apd_pkg.sv
`include "apd_defs.svh"

package apd_pkg;

    // engine state, one-hot
    typedef enum logic [1:0] {
        ENG_OFF = 2'b01,
        ENG_RUN = 2'b10
    } apd_eng_state_type;

    // output mode as held in control a
    typedef enum logic {
        MODE_NORMAL = 1'b0,
        MODE_GREEN = 1'b1
    } apd_mode_type;

    // last count of a pwm period for the selected bit count
    function automatic logic [11:0] apd_period_max(input logic [1:0] res);
        logic [4:0] bits;
        bits = `APD_RES_BASE + 5'(res);
        apd_period_max = 12'((13'h1 << bits) - 13'h1);
    endfunction

    // duty from the top of the sample; green mode folds the sign bit away
    function automatic logic [11:0] apd_duty(input logic [15:0] s, input logic [1:0] res,
                                             input logic green);
        logic [15:0] v;
        logic [4:0] sh;
        v = green ? {(s[15] ? s[14:0] : ~s[14:0]), 1'b0} : s;
        sh = `APD_SAMPLE_W - `APD_RES_BASE - 5'(res);
        apd_duty = 12'(v >> sh);
    endfunction

endpackage

// ### core/apd_pwm_if.sv
`timescale 1ns/1ps

// settings and waveforms between register file and pwm engine
interface apd_pwm_if;
    logic green;
    logic [1:0] res;
    logic enable;
    logic mute_n;
    logic [15:0] sample;
    logic pwm_a;
    logic pwm_b;

    modport ctrl (output green, output res, output enable, output mute_n, output sample,
                  input pwm_a, input pwm_b);
    modport core (input green, input res, input enable, input mute_n, input sample,
                  output pwm_a, output pwm_b);
endinterface

// ### core/apd_pwm_engine.sv
`timescale 1ns/1ps
`include "apd_defs.svh"

module apd_pwm_engine #(
    parameter int DIV = `APD_TICK_DIV
) (
    input wire logic clock,
    input wire logic rstn,
    apd_pwm_if.core bus
);
    localparam int DW = (DIV > 1) ? $clog2(DIV) : 1;

    if (DIV < 1) begin : g_bad_div
        $error("apd_pwm_engine: DIV must be at least 1");
    end

    apd_pkg::apd_eng_state_type state, next_state;
    logic [DW-1:0] div_cnt, next_div_cnt;
    logic [11:0] cnt, next_cnt;
    logic [15:0] cur_sample, next_cur_sample;
    logic pwm_a, next_pwm_a;
    logic pwm_b, next_pwm_b;
    logic tick;
    logic [11:0] duty;
    logic [11:0] pmax;
    logic on;
    logic active;

    ////////////////////////////////////////////////////////////////////////////
    // period counter and sample pick-up; a new sample only lands at a period
    // boundary so a write from software never cuts a pulse short
    always_comb begin
        tick = (div_cnt == DW'(DIV - 1));
        pmax = apd_pkg::apd_period_max(bus.res);
        next_state = state;
        next_div_cnt = tick ? '0 : DW'(div_cnt + 1'b1);
        next_cnt = cnt;
        next_cur_sample = cur_sample;
        unique case (state)
            apd_pkg::ENG_OFF: begin
                if (bus.enable) begin
                    next_state = apd_pkg::ENG_RUN;
                    next_cnt = '0;
                    next_div_cnt = '0;
                    next_cur_sample = `APD_FIRST_SAMPLE;
                end
            end
            apd_pkg::ENG_RUN: begin
                if (!bus.enable) begin
                    next_state = apd_pkg::ENG_OFF;
                end else if (tick) begin
                    // >= so a narrower resolution chosen mid-period still wraps
                    if (cnt >= pmax) begin
                        next_cnt = '0;
                        next_cur_sample = bus.sample;
                    end else begin
                        next_cnt = cnt + 12'h001;
                    end
                end
            end
            default: begin
                next_state = apd_pkg::ENG_OFF;
            end
        endcase
    end

    // waveform: normal drives the pins as a pair, green drives one pin per sign
    always_comb begin
        duty = apd_pkg::apd_duty(cur_sample, bus.res, bus.green);
        on = (cnt < duty);
        active = (state == apd_pkg::ENG_RUN) && bus.enable && bus.mute_n;
        if (bus.green) begin
            next_pwm_a = active && cur_sample[15] && on;
            next_pwm_b = active && !cur_sample[15] && on;
        end else begin
            next_pwm_a = active && on;
            next_pwm_b = active && !on;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state <= apd_pkg::ENG_OFF;
            div_cnt <= '0;
            cnt <= 12'h000;
            cur_sample <= 16'h0000;
            pwm_a <= 1'b0;
            pwm_b <= 1'b0;
        end else begin
            state <= next_state;
            div_cnt <= next_div_cnt;
            cnt <= next_cnt;
            cur_sample <= next_cur_sample;
            pwm_a <= next_pwm_a;
            pwm_b <= next_pwm_b;
        end
    end

    assign bus.pwm_a = pwm_a;
    assign bus.pwm_b = pwm_b;

    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    property p_first_mid;
        (state == apd_pkg::ENG_OFF && bus.enable) |=> (cur_sample == 16'h8000) [*2];
    endproperty
    a_first_mid: assert property (p_first_mid) else $error("first value not mid scale");

    property p_wrap;
        (state == apd_pkg::ENG_RUN && bus.enable && tick && cnt == pmax)
            |=> (cnt == 12'h000 && cur_sample == $past(bus.sample));
    endproperty
    a_wrap: assert property (p_wrap) else $error("period did not wrap");

    property p_green_one_pin;
        bus.green && $past(bus.green) |-> !(pwm_a && pwm_b);
    endproperty
    a_green_one_pin: assert property (p_green_one_pin) else $error("both pins high");

    property p_normal_pair;
        (state == apd_pkg::ENG_RUN && bus.enable && bus.mute_n && !bus.green)
            |=> (pwm_a != pwm_b);
    endproperty
    a_normal_pair: assert property (p_normal_pair) else $error("normal pair broken");

    property p_muted;
        (!bus.mute_n || !bus.enable) |=> (!pwm_a && !pwm_b);
    endproperty
    a_muted: assert property (p_muted) else $error("output while muted");

    property p_top_bits;
        (state == apd_pkg::ENG_RUN && !bus.green && bus.res == 2'b00 && bus.enable
            && bus.mute_n) |=> (pwm_a == ($past(cnt) < 12'($past(cur_sample) >> 7)));
    endproperty
    a_top_bits: assert property (p_top_bits) else $error("duty not from top bits");

endmodule

// ### core/apd_audio_pwm.sv
`timescale 1ns/1ps
`include "apd_defs.svh"

// Notes on behaviour
// - up to 13 bits green, 12 normal
// - sample register pair drives both speaker pins
// - four-bit code picks sixteen drive levels
// - resolution code selects 9 to 12 bits
// - effective bits taken from sample top
// - green mode adds one sign bit
// - unimplemented strength and control bits read zero
// - driver disabled floats both speaker pins
// - first value after enable is 8000h
module apd_audio_pwm #(
    parameter int DIV = `APD_TICK_DIV
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic speaker_out_a,
    output logic speaker_out_a_oe,
    output logic speaker_out_b,
    output logic speaker_out_b_oe,
    output logic [3:0] strength_code
);
    if (DIV < 1) begin : g_bad_div
        $error("apd_audio_pwm: DIV must be at least 1");
    end

    ////////////////////////////////////////////////////////////////////////////
    // register storage
    logic [7:0] output_strength_level, next_output_strength_level;
    logic [7:0] audio_pwm_control_a, next_audio_pwm_control_a;
    logic [7:0] audio_pwm_control_b, next_audio_pwm_control_b;
    logic [7:0] sample_data_low, next_sample_data_low;
    logic [7:0] sample_data_high, next_sample_data_high;

    // apb answer
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;

    logic access;
    logic commit;
    logic hit;
    logic [7:0] rd_byte;

    apd_pwm_if pwm_bus();

    ////////////////////////////////////////////////////////////////////////////
    // address decode; unused offsets give zero and an error answer
    always_comb begin
        hit = 1'b1;
        rd_byte = 8'h00;
        unique case (paddr)
            `APD_OFF_STRENGTH: rd_byte = output_strength_level & `APD_STRENGTH_MASK;
            `APD_OFF_CTRL_A: rd_byte = audio_pwm_control_a & `APD_CTRL_A_MASK;
            `APD_OFF_CTRL_B: rd_byte = audio_pwm_control_b & `APD_CTRL_B_MASK;
            `APD_OFF_SAMPLE_LO: rd_byte = sample_data_low;
            `APD_OFF_SAMPLE_HI: rd_byte = sample_data_high;
            default: hit = 1'b0;
        endcase
    end

    // one wait state: pready rises on the second access cycle so the read
    // data can come from a flip-flop
    always_comb begin
        access = psel && penable && !pready;
        commit = psel && penable && pready;
        next_pready = access;
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        if (access) begin
            next_pslverr = !hit;
            if (!pwrite) begin
                next_prdata = {24'h00_0000, rd_byte};
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register writes take effect at the edge that completes the transfer;
    // reserved bits are never stored so they cannot leak back on a read
    always_comb begin
        next_output_strength_level = output_strength_level;
        next_audio_pwm_control_a = audio_pwm_control_a;
        next_audio_pwm_control_b = audio_pwm_control_b;
        next_sample_data_low = sample_data_low;
        next_sample_data_high = sample_data_high;
        if (commit && pwrite) begin
            unique case (paddr)
                `APD_OFF_STRENGTH: begin
                    next_output_strength_level = pwdata[7:0] & `APD_STRENGTH_MASK;
                end
                `APD_OFF_CTRL_A: begin
                    next_audio_pwm_control_a = pwdata[7:0] & `APD_CTRL_A_MASK;
                end
                `APD_OFF_CTRL_B: begin
                    // buffer flags are not modelled, only the writable bits
                    next_audio_pwm_control_b = pwdata[7:0] & `APD_CTRL_B_MASK;
                end
                `APD_OFF_SAMPLE_LO: begin
                    next_sample_data_low = pwdata[7:0];
                end
                `APD_OFF_SAMPLE_HI: begin
                    next_sample_data_high = pwdata[7:0];
                end
                default: begin
                    next_sample_data_high = sample_data_high;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            output_strength_level <= `APD_STRENGTH_RST;
            audio_pwm_control_a <= `APD_CTRL_A_RST;
            audio_pwm_control_b <= `APD_CTRL_B_RST;
            sample_data_low <= `APD_SAMPLE_RST;
            sample_data_high <= `APD_SAMPLE_RST;
        end else begin
            output_strength_level <= next_output_strength_level;
            audio_pwm_control_a <= next_audio_pwm_control_a;
            audio_pwm_control_b <= next_audio_pwm_control_b;
            sample_data_low <= next_sample_data_low;
            sample_data_high <= next_sample_data_high;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // settings handed to the engine; the sample pair is read whole, so
    // software should write the low byte first and the high byte last
    assign pwm_bus.green = audio_pwm_control_a[`APD_CA_MODE];
    assign pwm_bus.res = audio_pwm_control_a[`APD_CA_RES_HI:`APD_CA_RES_LO];
    assign pwm_bus.enable = audio_pwm_control_a[`APD_CA_EN];
    assign pwm_bus.mute_n = audio_pwm_control_a[`APD_CA_MUTE_N];
    assign pwm_bus.sample = {sample_data_high, sample_data_low};

    apd_pwm_engine #(
        .DIV(DIV)
    ) u_engine (
        .clock(clock),
        .rstn(rstn),
        .bus(pwm_bus.core)
    );

    // pins come straight from engine and register flip-flops
    assign speaker_out_a = pwm_bus.pwm_a;
    assign speaker_out_b = pwm_bus.pwm_b;
    assign speaker_out_a_oe = audio_pwm_control_a[`APD_CA_DRV];
    assign speaker_out_b_oe = audio_pwm_control_a[`APD_CA_DRV];
    assign strength_code = output_strength_level[3:0];

    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    property p_strength_rsvd;
        (commit && !pwrite && paddr == 8'h00) |-> (prdata[7:4] == 4'h0);
    endproperty
    a_strength_rsvd: assert property (p_strength_rsvd) else $error("strength rsvd bits");

    property p_ctrl_a_rsvd;
        (commit && !pwrite && paddr == 8'h04) |-> (prdata[4] == 1'b0 && prdata[31:8] == 24'h0);
    endproperty
    a_ctrl_a_rsvd: assert property (p_ctrl_a_rsvd) else $error("control a bit 4 set");

    property p_float;
        (commit && pwrite && paddr == 8'h04) |=> (speaker_out_a_oe == $past(pwdata[1])
            && speaker_out_b_oe == $past(pwdata[1]));
    endproperty
    a_float: assert property (p_float) else $error("pins driven while disabled");

    property p_strength_write;
        (commit && pwrite && paddr == 8'h00) |=> (strength_code == $past(pwdata[3:0]));
    endproperty
    a_strength_write: assert property (p_strength_write) else $error("strength not applied");

    property p_mode_write;
        (commit && pwrite && paddr == 8'h04) |=> (pwm_bus.green == $past(pwdata[7])
            && pwm_bus.res == $past(pwdata[6:5]));
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode or res not applied");

    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held two cycles");

    property p_sample_write;
        (commit && pwrite && paddr == 8'h10) |=> (pwm_bus.sample[15:8] == $past(pwdata[7:0]));
    endproperty
    a_sample_write: assert property (p_sample_write) else $error("sample high not stored");

endmodule

// ### tb/apd_spk_model.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// speaker load on the two pwm pins; counts the cycles each wire sits high
module apd_spk_model (
    input wire logic clock,
    input wire logic speaker_out_a,
    input wire logic speaker_out_a_oe,
    input wire logic speaker_out_b,
    input wire logic speaker_out_b_oe,
    output logic line_a,
    output logic line_b,
    output logic [15:0] cnt_a,
    output logic [15:0] cnt_b
);
    // no pull on the speaker wires, so a released pin really floats
    assign line_a = speaker_out_a_oe ? speaker_out_a : 1'bz;
    assign line_b = speaker_out_b_oe ? speaker_out_b : 1'bz;

    // high time per wire; the average over whole periods is the duty heard
    initial begin
        cnt_a = 16'h0000;
        cnt_b = 16'h0000;
    end
    always @(posedge clock) begin
        if (line_a === 1'b1) begin
            cnt_a <= cnt_a + 16'h0001;
        end
        if (line_b === 1'b1) begin
            cnt_b <= cnt_b + 16'h0001;
        end
    end
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
`include "apd_defs.svh"

`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb;
    typedef struct {logic [7:0] addr; logic [31:0] wd; logic [31:0] rd; logic err;} apd_row_type;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, out_a, oe_a, out_b, oe_b, line_a, line_b;
    logic [3:0] strength_code;
    logic [15:0] cnt_a, cnt_b, da, db;
    logic [31:0] rd;
    logic e;
    int err_count = 0;
    int total_checks = 0;
    apd_row_type rows [6] = '{
        '{`APD_OFF_STRENGTH, 32'hffff_ffff, 32'h0000_000f, 1'b0},
        '{`APD_OFF_CTRL_A, 32'h0000_0076, 32'h0000_0066, 1'b0},
        '{`APD_OFF_CTRL_B, 32'h0000_00ff, 32'h0000_008f, 1'b0},
        '{`APD_OFF_SAMPLE_LO, 32'h0000_00a5, 32'h0000_00a5, 1'b0},
        '{`APD_OFF_SAMPLE_HI, 32'h0000_005a, 32'h0000_005a, 1'b0},
        '{8'h14, 32'h0000_003c, 32'h0000_0000, 1'b1}};

    always #50 clock = ~clock;

    apd_audio_pwm #(.DIV(1)) i_dut (
        .clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .speaker_out_a(out_a), .speaker_out_a_oe(oe_a), .speaker_out_b(out_b),
        .speaker_out_b_oe(oe_b), .strength_code(strength_code));

    apd_spk_model i_spk (
        .clock(clock), .speaker_out_a(out_a), .speaker_out_a_oe(oe_a), .speaker_out_b(out_b),
        .speaker_out_b_oe(oe_b), .line_a(line_a), .line_b(line_b), .cnt_a(cnt_a),
        .cnt_b(cnt_b));

    ////////////////////////////////////////////////////////////////////////////////
    // one apb transfer; waits at most 20 access cycles for pready, then gives up
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                       output logic [31:0] rdat, output logic err);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        // a slave that never answers counts as a mismatch
        if (pready !== 1'b1) begin
            err_count++;
        end
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        logic [31:0] r;
        logic x;
        apb(1'b1, addr, {24'h000000, data}, r, x);
    endtask

    // settle a full period after the change, then measure exactly one period
    task automatic pwm_run(input logic [7:0] ctrl, input logic [7:0] hi, input int period);
        logic [15:0] a0, b0;
        wr(`APD_OFF_SAMPLE_HI, hi);
        wr(`APD_OFF_CTRL_A, ctrl);
        repeat (period + 16) @(posedge clock);
        a0 = cnt_a;
        b0 = cnt_b;
        repeat (period) @(posedge clock);
        da = cnt_a - a0;
        db = cnt_b - b0;
    endtask

    task automatic give_verdict();
        $display("errors %0d checks %0d", err_count, total_checks);
        if (err_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog sized well above the longest pwm windows below
    initial begin
        repeat (60000) @(posedge clock);
        err_count++;
        give_verdict();
    end

    initial begin
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        `CHK(strength_code, 4'h4)
        `CHK(line_a, 1'bz)
        apb(1'b0, `APD_OFF_STRENGTH, 32'h0, rd, e);
        `CHK(rd, 32'h0000_0004)
        apb(1'b0, `APD_OFF_CTRL_A, 32'h0, rd, e);
        `CHK(rd, 32'h0000_0000)
        // register rows: write, read back, masked bits and the unmapped slot
        foreach (rows[i]) begin
            apb(1'b1, rows[i].addr, rows[i].wd, rd, e);
            apb(1'b0, rows[i].addr, 32'h0, rd, e);
            `CHK(rd, rows[i].rd)
            `CHK(e, rows[i].err)
        end
        // every drive code reaches the strength pins
        for (int c = 0; c < 16; c++) begin
            wr(`APD_OFF_STRENGTH, 8'(c));
            repeat (2) @(posedge clock);
            `CHK(strength_code, 4'(c))
        end
        // driver on but function off holds low; driver off floats both wires
        repeat (2) @(posedge clock);
        `CHK(line_a, 1'b0)
        wr(`APD_OFF_CTRL_A, 8'h64);
        repeat (2) @(posedge clock);
        `CHK(line_a, 1'bz)
        `CHK(line_b, 1'bz)
        // silent sample, so only the forced mid value of the first period shows
        wr(`APD_OFF_SAMPLE_LO, 8'h00);
        wr(`APD_OFF_SAMPLE_HI, 8'h00);
        wr(`APD_OFF_CTRL_A, 8'h0b);
        da = cnt_a;
        repeat (1024) @(posedge clock);
        `CHK(16'(cnt_a - da), 16'h0100)
        // normal mode at each resolution: duty from the sample top, pins complementary
        for (int r = 0; r < 4; r++) begin
            pwm_run({1'b0, 2'(r), 5'h0b}, 8'h40, 512 << r);
            `CHK(da, 16'(128 << r))
            `CHK(db, 16'((512 << r) - (128 << r)))
        end
        // green mode at the widest setting: sign picks the pin, magnitude the width
        pwm_run(8'heb, 8'hc0, 4096);
        `CHK(da, 16'h0800)
        `CHK(db, 16'h0000)
        pwm_run(8'heb, 8'h40, 4096);
        `CHK(da, 16'h0000)
        `CHK(db, 16'h07ff)
        // muted output stays quiet on both wires
        pwm_run(8'h03, 8'h40, 512);
        `CHK(da, 16'h0000)
        `CHK(db, 16'h0000)
        give_verdict();
    end
endmodule
